// *** hdl/ddrpp_dev.sv ***
// Device-side command, power, data and alert logic of a DDR4 module.
// Assumes every pin is asynchronous and oversampled by core_clk_i.
module ddrpp_dev import ddrpp_pkg::*; #(
  parameter int unsigned DQ_W = 8,  // Byte lane width
  parameter bit          X16  = 0   // Part has only one group bit
) (
  input  wire logic              core_clk_i,   // Core clock
  input  wire logic              rst_n_i,      // Sync reset, low
  input  wire logic              ck_t_i,       // Link clock true
  input  wire logic              ck_c_i,       // Link clock complement
  input  wire logic              cke_i,        // Clock enable
  input  wire logic              cs_n_i,       // Chip select, low
  input  wire logic              act_n_i,      // Activate, low
  input  wire logic              ras_n_i,      // Row strobe / A16
  input  wire logic              cas_n_i,      // Column strobe / A15
  input  wire logic              we_n_i,       // Write enable / A14
  input  wire logic [1:0]        bg_i,         // Bank group
  input  wire logic [1:0]        ba_i,         // Bank
  input  wire logic [ADDR_W-1:0] a_i,          // Address A13..A0
  input  wire logic              odt_i,        // Termination control
  input  wire logic              par_i,        // Command parity
  input  wire logic              dram_rst_n_i, // Device reset pin, low
  input  wire logic              dqs_t_i,      // Write strobe true
  input  wire logic              dqs_c_i,      // Write strobe complement
  input  wire logic [DQ_W-1:0]   dq_i,         // Data in
  input  wire logic              dm_dbi_n_i,   // Mask / inversion in
  input  wire logic [DQ_W*8-1:0] rd_data_i,    // Read burst, beat 0 low
  output logic                   cmd_valid_o,  // Command taken pulse
  output ddrpp_cmd_type          cmd_code_o,   // Decoded command
  output logic [1:0]             cmd_bg_o,     // Command bank group
  output logic [1:0]             cmd_ba_o,     // Command bank
  output logic [16:0]            cmd_addr_o,   // Row, column or opcode
  output logic                   auto_pre_o,   // Auto precharge
  output logic                   burst_chop_o, // Burst of four
  output logic                   pre_all_o,    // Precharge all
  output logic [15:0]            bank_open_o,  // Open rows
  output ddrpp_pwr_type          pwr_state_o,  // Power state
  output logic                   odt_en_o,     // Termination on
  output logic                   alert_n_o,    // Alert, low
  output logic                   wr_valid_o,   // Kept write beat
  output logic [DQ_W-1:0]        wr_data_o,    // Write beat to store
  output logic [DQ_W-1:0]        dq_o,         // Read data out
  output logic                   dq_oe_o,      // Data drive enable
  output logic                   dqs_t_o,      // Read strobe true
  output logic                   dqs_c_o,      // Read strobe complement
  output logic                   dqs_oe_o,     // Strobe drive enable
  output logic                   dbi_n_o,      // Read inversion flag
  output logic                   dbi_oe_o      // Flag drive enable
);
  localparam int unsigned IN_W = 18 + ADDR_W + DQ_W;

  initial begin
    if (DQ_W < 8) $error("DQ_W below 8 cannot carry the CRC byte");
  end

  logic [IN_W-1:0] s1_ff;
  logic [IN_W-1:0] s2_ff;
  logic p_ck_t, p_ck_c, p_cke, p_cs_n, p_act_n, p_ras_n, p_cas_n, p_we_n;
  logic [1:0] p_bg, p_ba;
  logic [ADDR_W-1:0] p_a;
  logic p_odt, p_par, p_rst_n, p_dqs_t, p_dqs_c, p_dm;
  logic [DQ_W-1:0] p_dq;

  // Pins are read only after the second stage
  always_ff @(posedge core_clk_i) begin
    s1_ff <= {ck_t_i, ck_c_i, cke_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, bg_i, ba_i, a_i,
              odt_i, par_i, dram_rst_n_i, dqs_t_i, dqs_c_i, dq_i, dm_dbi_n_i};
    s2_ff <= s1_ff;
  end
  assign {p_ck_t, p_ck_c, p_cke, p_cs_n, p_act_n, p_ras_n, p_cas_n, p_we_n, p_bg, p_ba, p_a,
          p_odt, p_par, p_rst_n, p_dqs_t, p_dqs_c, p_dq, p_dm} = s2_ff;

  logic clr;
  assign clr = !rst_n_i || !p_rst_n;

  // Command group state
  logic ck_prev_ff, nxt_ck_prev;
  logic cmd_valid_ff, nxt_cmd_valid;
  ddrpp_cmd_type cmd_code_ff, nxt_cmd_code;
  logic [1:0] cmd_bg_ff, nxt_cmd_bg, cmd_ba_ff, nxt_cmd_ba;
  logic [16:0] cmd_addr_ff, nxt_cmd_addr;
  logic auto_pre_ff, nxt_auto_pre, chop_ff, nxt_chop, pre_all_ff, nxt_pre_all;
  logic [15:0] bank_open_ff, nxt_bank_open;
  ddrpp_pwr_type pwr_ff, nxt_pwr;
  logic odt_en_ff, nxt_odt_en;
  logic [ADDR_W-1:0] mr_ff [8];
  logic [ADDR_W-1:0] nxt_mr [8];
  // Alert group state
  logic [ALERT_CNT_W-1:0] alert_cnt_ff, nxt_alert_cnt;
  logic par_hold_ff, nxt_par_hold, alert_n_ff, nxt_alert_n;
  // Write group state
  logic dqs_prev_ff, nxt_dqs_prev;
  logic [3:0] wr_left_ff, nxt_wr_left;
  logic crc_pend_ff, nxt_crc_pend;
  logic [7:0] crc_ff, nxt_crc;
  logic wr_valid_ff, nxt_wr_valid;
  logic [DQ_W-1:0] wr_data_ff, nxt_wr_data;
  // Read group state
  logic [3:0] rd_left_ff, nxt_rd_left;
  logic [DQ_W*8-1:0] rd_shift_ff, nxt_rd_shift;
  logic [DQ_W-1:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe, dqs_ff, nxt_dqs, dbi_n_ff, nxt_dbi_n;

  // Decode helpers
  logic ck_rise, sel, par_on, par_bad, par_err, take, crc_err, dqs_edge;
  logic [1:0] bg_eff;
  logic [3:0] bank_idx;
  logic [3:0] burst_len;
  ddrpp_cmd_type dec;
  logic dm_en, wdbi_en, rdbi_en, crc_en, rtt_on, chop_now;

  assign ck_rise  = p_ck_t && !ck_prev_ff && !p_ck_c;
  assign bg_eff   = X16 ? {1'b0, p_bg[0]} : p_bg;
  assign bank_idx = {bg_eff, p_ba};
  assign par_on   = mr_ff[MR5_IDX][MR5_PAR_LO +: 3] != 3'h0;
  assign par_bad  = ^{p_act_n, p_ras_n, p_cas_n, p_we_n, bg_eff, p_ba, p_a, p_par};
  // Commands are dropped in power states and while parity recovery runs
  assign sel      = ck_rise && !p_cs_n && p_cke && pwr_ff == PS_ACTIVE && !par_hold_ff;
  assign par_err  = sel && par_on && par_bad;
  assign take     = sel && !par_err;
  // DM is lost when the x8 pin serves as termination strobe
  assign dm_en    = mr_ff[MR5_IDX][MR5_DM_BIT] && !mr_ff[MR1_IDX][MR1_TDQS_BIT];
  assign wdbi_en  = mr_ff[MR5_IDX][MR5_WDBI_BIT];
  assign rdbi_en  = mr_ff[MR5_IDX][MR5_RDBI_BIT];
  assign crc_en   = mr_ff[MR2_IDX][MR2_WCRC_BIT];
  assign rtt_on   = mr_ff[MR1_IDX][MR1_RTT_NOM_LO +: 3] != 3'h0 || mr_ff[MR5_IDX][MR5_RTT_PARK_LO +: 3] != 3'h0;
  assign dqs_edge = p_dqs_t != dqs_prev_ff && p_dqs_t != p_dqs_c;

  always_comb begin
    unique case (mr_ff[MR0_IDX][MR_BL_LO +: 2])
      BL_ON_FLY: chop_now = !p_a[12];
      BL_FIXED4: chop_now = 1'b1;
      default:   chop_now = 1'b0;
    endcase
    burst_len = chop_now ? 4'(BURST_CHOP) : 4'(BURST_FULL);
    if (!p_act_n) begin
      dec = CMD_ACT;
    end else begin
      unique case ({p_ras_n, p_cas_n, p_we_n})
        3'h0: dec = CMD_MRS;
        3'h1: dec = CMD_REF;
        3'h2: dec = CMD_PRE;
        3'h3: dec = CMD_RFU;
        3'h4: dec = CMD_WR;
        3'h5: dec = CMD_RD;
        3'h6: dec = CMD_ZQ;
        default: dec = CMD_NOP;
      endcase
    end
  end

  // Command, bank and power group
  always_comb begin
    nxt_ck_prev   = p_ck_t;
    nxt_cmd_valid = take;
    nxt_cmd_code  = cmd_code_ff;
    nxt_cmd_bg    = cmd_bg_ff;
    nxt_cmd_ba    = cmd_ba_ff;
    nxt_cmd_addr  = cmd_addr_ff;
    nxt_auto_pre  = auto_pre_ff;
    nxt_chop      = chop_ff;
    nxt_pre_all   = pre_all_ff;
    nxt_bank_open = bank_open_ff;
    nxt_pwr       = pwr_ff;
    nxt_odt_en    = odt_en_ff;
    nxt_mr        = mr_ff;
    if (take) begin
      nxt_cmd_code = dec;
      nxt_cmd_bg   = bg_eff;
      nxt_cmd_ba   = p_ba;
      nxt_cmd_addr = {p_ras_n, p_cas_n, p_we_n, p_a};
      nxt_auto_pre = (dec == CMD_RD || dec == CMD_WR) && p_a[10];
      nxt_chop     = (dec == CMD_RD || dec == CMD_WR) && chop_now;
      nxt_pre_all  = dec == CMD_PRE && p_a[10];
      unique case (dec)
        CMD_ACT: nxt_bank_open[bank_idx] = 1'b1;
        CMD_PRE: begin
          if (p_a[10]) begin
            nxt_bank_open = 16'h0000;
          end else begin
            nxt_bank_open[bank_idx] = 1'b0;
          end
        end
        // Row closes at once; the array model owns the tail timing
        CMD_RD, CMD_WR: begin
          if (p_a[10]) begin
            nxt_bank_open[bank_idx] = 1'b0;
          end
        end
        CMD_MRS: nxt_mr[{bg_eff[0], p_ba}] = p_a;
        default: nxt_bank_open = bank_open_ff;
      endcase
    end
    unique case (pwr_ff)
      PS_ACTIVE: begin
        // Bursts finish first; the host keeps the enable high meanwhile
        if (ck_rise && !p_cke && wr_left_ff == 4'h0 && rd_left_ff == 4'h0) begin
          if (!p_cs_n && p_act_n && {p_ras_n, p_cas_n, p_we_n} == 3'h1 && bank_open_ff == 16'h0000) begin
            nxt_pwr = PS_SELF_REF;
          end else if (bank_open_ff != 16'h0000) begin
            nxt_pwr = PS_PD_ACT;
          end else begin
            nxt_pwr = PS_PD_PRE;
          end
        end
      end
      PS_PD_PRE, PS_PD_ACT: begin
        if (ck_rise && p_cke) begin
          nxt_pwr = PS_ACTIVE;
        end
      end
      PS_SELF_REF: begin
        // No clock edge needed to leave self refresh
        if (p_cke) begin
          nxt_pwr = PS_ACTIVE;
        end
      end
    endcase
    if (nxt_pwr == PS_SELF_REF) begin
      nxt_odt_en = 1'b0;
    end else if (ck_rise) begin
      nxt_odt_en = p_odt && rtt_on;
    end
  end

  // Alert group: parity recovery outranks a CRC pulse
  always_comb begin
    nxt_alert_cnt = alert_cnt_ff;
    nxt_par_hold  = par_hold_ff;
    if (par_err) begin
      nxt_alert_cnt = ALERT_CNT_W'(PAR_REC_CYC);
      nxt_par_hold  = 1'b1;
    end else if (alert_cnt_ff != '0) begin
      nxt_alert_cnt = alert_cnt_ff - 1'b1;
      if (alert_cnt_ff == 1) begin
        nxt_par_hold = 1'b0;
      end
    end else if (crc_err) begin
      nxt_alert_cnt = ALERT_CNT_W'(ALERT_PULSE_CYC);
    end
    nxt_alert_n = nxt_alert_cnt == '0;
  end

  // Write group: beats taken on both strobe edges
  always_comb begin
    nxt_dqs_prev = p_dqs_t;
    nxt_wr_left  = wr_left_ff;
    nxt_crc_pend = crc_pend_ff;
    nxt_crc      = crc_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_data  = wr_data_ff;
    crc_err      = 1'b0;
    if (take && dec == CMD_WR) begin
      nxt_wr_left  = burst_len;
      nxt_crc_pend = crc_en;
      nxt_crc      = 8'h00;
    end else if (dqs_edge && wr_left_ff != 4'h0) begin
      nxt_wr_left  = wr_left_ff - 4'h1;
      nxt_wr_valid = !(dm_en && !p_dm);
      nxt_wr_data  = (wdbi_en && !p_dm) ? ~p_dq : p_dq;
      nxt_crc      = crc_ff;
      for (int i = 0; i < DQ_W; i++) begin
        nxt_crc = {nxt_crc[6:0], 1'b0} ^ ((nxt_crc[7] ^ p_dq[i]) ? CRC_POLY : 8'h00);
      end
    end else if (dqs_edge && crc_pend_ff) begin
      nxt_crc_pend = 1'b0;
      crc_err      = p_dq[7:0] != crc_ff;
    end
  end

  // Read group: one beat per core cycle, strobe toggles with data
  always_comb begin
    nxt_rd_left  = rd_left_ff;
    nxt_rd_shift = rd_shift_ff;
    nxt_dq       = dq_ff;
    nxt_dq_oe    = 1'b0;
    nxt_dqs      = 1'b0;
    nxt_dbi_n    = 1'b1;
    if (take && dec == CMD_RD) begin
      nxt_rd_left  = burst_len;
      nxt_rd_shift = rd_data_i;
    end else if (rd_left_ff != 4'h0) begin
      nxt_rd_left  = rd_left_ff - 4'h1;
      nxt_rd_shift = rd_shift_ff >> DQ_W;
      nxt_dq_oe    = 1'b1;
      nxt_dqs      = !rd_left_ff[0];
      // Invert when most bits are zero to cut driven lows
      if (rdbi_en && $countones(~rd_shift_ff[DQ_W-1:0]) > DQ_W / 2) begin
        nxt_dq    = ~rd_shift_ff[DQ_W-1:0];
        nxt_dbi_n = 1'b0;
      end else begin
        nxt_dq    = rd_shift_ff[DQ_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      ck_prev_ff   <= 1'b0;
      cmd_valid_ff <= 1'b0;
      cmd_code_ff  <= CMD_NONE;
      cmd_bg_ff    <= 2'h0;
      cmd_ba_ff    <= 2'h0;
      cmd_addr_ff  <= 17'h00000;
      auto_pre_ff  <= 1'b0;
      chop_ff      <= 1'b0;
      pre_all_ff   <= 1'b0;
      bank_open_ff <= 16'h0000;
      pwr_ff       <= PS_ACTIVE;
      odt_en_ff    <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        mr_ff[i] <= MR_RESET;
      end
      alert_cnt_ff <= '0;
      par_hold_ff  <= 1'b0;
      alert_n_ff   <= 1'b1;
      dqs_prev_ff  <= 1'b0;
      wr_left_ff   <= 4'h0;
      crc_pend_ff  <= 1'b0;
      crc_ff       <= 8'h00;
      wr_valid_ff  <= 1'b0;
      wr_data_ff   <= '0;
      rd_left_ff   <= 4'h0;
      rd_shift_ff  <= '0;
      dq_ff        <= '0;
      dq_oe_ff     <= 1'b0;
      dqs_ff       <= 1'b0;
      dbi_n_ff     <= 1'b1;
    end else begin
      ck_prev_ff   <= nxt_ck_prev;
      cmd_valid_ff <= nxt_cmd_valid;
      cmd_code_ff  <= nxt_cmd_code;
      cmd_bg_ff    <= nxt_cmd_bg;
      cmd_ba_ff    <= nxt_cmd_ba;
      cmd_addr_ff  <= nxt_cmd_addr;
      auto_pre_ff  <= nxt_auto_pre;
      chop_ff      <= nxt_chop;
      pre_all_ff   <= nxt_pre_all;
      bank_open_ff <= nxt_bank_open;
      pwr_ff       <= nxt_pwr;
      odt_en_ff    <= nxt_odt_en;
      mr_ff        <= nxt_mr;
      alert_cnt_ff <= nxt_alert_cnt;
      par_hold_ff  <= nxt_par_hold;
      alert_n_ff   <= nxt_alert_n;
      dqs_prev_ff  <= nxt_dqs_prev;
      wr_left_ff   <= nxt_wr_left;
      crc_pend_ff  <= nxt_crc_pend;
      crc_ff       <= nxt_crc;
      wr_valid_ff  <= nxt_wr_valid;
      wr_data_ff   <= nxt_wr_data;
      rd_left_ff   <= nxt_rd_left;
      rd_shift_ff  <= nxt_rd_shift;
      dq_ff        <= nxt_dq;
      dq_oe_ff     <= nxt_dq_oe;
      dqs_ff       <= nxt_dqs;
      dbi_n_ff     <= nxt_dbi_n;
    end
  end

  assign cmd_valid_o  = cmd_valid_ff;
  assign cmd_code_o   = cmd_code_ff;
  assign cmd_bg_o     = cmd_bg_ff;
  assign cmd_ba_o     = cmd_ba_ff;
  assign cmd_addr_o   = cmd_addr_ff;
  assign auto_pre_o   = auto_pre_ff;
  assign burst_chop_o = chop_ff;
  assign pre_all_o    = pre_all_ff;
  assign bank_open_o  = bank_open_ff;
  assign pwr_state_o  = pwr_ff;
  assign odt_en_o     = odt_en_ff;
  assign alert_n_o    = alert_n_ff;
  assign wr_valid_o   = wr_valid_ff;
  assign wr_data_o    = wr_data_ff;
  assign dq_o         = dq_ff;
  assign dq_oe_o      = dq_oe_ff;
  assign dqs_t_o      = dqs_ff;
  assign dqs_c_o      = !dqs_ff;
  assign dqs_oe_o     = dq_oe_ff;
  assign dbi_n_o      = dbi_n_ff;
  assign dbi_oe_o     = dq_oe_ff;

  cs_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ck_rise && p_cs_n |=> !cmd_valid_o) else $error("command taken with chip select high");
  act_row_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    take && !p_act_n |=> cmd_code_o == CMD_ACT && cmd_addr_o[16:14] == $past({p_ras_n, p_cas_n, p_we_n}))
    else $error("activate row bits wrong");
  auto_pre_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    take && dec == CMD_RD && p_a[10] |=> auto_pre_o && !bank_open_o[$past(bank_idx)])
    else $error("auto precharge not applied");
  pre_all_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    take && dec == CMD_PRE && p_a[10] |=> pre_all_o && bank_open_o == 16'h0000)
    else $error("precharge all left a bank open");
  par_alert_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    par_err |=> !alert_n_o [*8] ##1 (!alert_n_o && !cmd_valid_o)) else $error("parity alert not held");
  sr_odt_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pwr_state_o == PS_SELF_REF |-> !odt_en_o) else $error("termination on in self refresh");
  pd_cmd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pwr_ff != PS_ACTIVE |=> !cmd_valid_o) else $error("command taken while powered down");
  wr_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dqs_edge && wr_left_ff != 4'h0 && dm_en && !p_dm |=> !wr_valid_o) else $error("masked beat kept");
  wr_dbi_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dqs_edge && wr_left_ff != 4'h0 && wdbi_en && !p_dm |=> wr_data_o == ~$past(p_dq))
    else $error("inverted beat not restored");
  rd_burst_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(dq_oe_o) |-> dqs_t_o ##1 (dq_oe_o && !dqs_t_o) ##1 (dq_oe_o && dqs_t_o))
    else $error("read strobe not toggling with data");
endmodule

// *** hdl/ddrpp_pkg.sv ***
// Constants and types for the DDR4 module pin-protocol device block.
// Assumes a 250 MHz core clock that oversamples every module pin.
// Functional notes
// - Address carries row, column or mode opcode
// - A10 on read/write requests auto precharge
// - A10 on precharge selects one or all banks
// - A12 low on read/write chops the burst
// - ACT_n low: RAS/CAS/WE become row bits 16..14
// - ACT_n high: RAS/CAS/WE encode other commands
// - Bank and group pick bank or mode register
// - x8 uses two group bits, x16 only one
// - Inputs sampled on rising true clock crossing
// - Clock enable low enters power-down or self refresh
// - Power-down and self refresh disable input buffers
// - Chip select high masks every command
// - Termination follows ODT unless mode disables it
// - Parity checked over command and address when enabled
// - Reset pin low resets the device
// - Write CRC follows last data beat when enabled
// - Mask low discards that write beat
// - Mode registers pick mask, inversion or strobe use
// - Inversion flag low means data is inverted
// - Strobe edge-aligned on reads, lanes per byte
// - Alert pulses on CRC, holds on parity error
package ddrpp_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned ALERT_PULSE_NS  = 40;
  localparam int unsigned PAR_RECOVERY_NS = 200;
  localparam int unsigned ALERT_PULSE_CYC = (ALERT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PAR_REC_CYC     = (PAR_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ALERT_CNT_W     = 8;
  localparam int unsigned ADDR_W          = 14;
  localparam int unsigned BURST_FULL      = 8;
  localparam int unsigned BURST_CHOP      = 4;
  localparam int unsigned MR_BL_LO        = 0;
  localparam int unsigned MR1_RTT_NOM_LO  = 8;
  localparam int unsigned MR1_TDQS_BIT    = 11;
  localparam int unsigned MR2_WCRC_BIT    = 12;
  localparam int unsigned MR5_PAR_LO      = 0;
  localparam int unsigned MR5_RTT_PARK_LO = 6;
  localparam int unsigned MR5_DM_BIT      = 10;
  localparam int unsigned MR5_WDBI_BIT    = 11;
  localparam int unsigned MR5_RDBI_BIT    = 12;
  localparam logic [2:0]  MR0_IDX         = 3'h0;
  localparam logic [2:0]  MR1_IDX         = 3'h1;
  localparam logic [2:0]  MR2_IDX         = 3'h2;
  localparam logic [2:0]  MR5_IDX         = 3'h5;
  localparam logic [1:0]  BL_FIXED8       = 2'h0;
  localparam logic [1:0]  BL_ON_FLY       = 2'h1;
  localparam logic [1:0]  BL_FIXED4       = 2'h2;
  localparam logic [7:0]  CRC_POLY        = 8'h07;
  localparam logic [ADDR_W-1:0] MR_RESET  = 14'h0000;

  typedef enum logic [3:0] {CMD_NONE, CMD_MRS, CMD_REF, CMD_PRE, CMD_RFU,
                            CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP, CMD_ACT} ddrpp_cmd_type;
  typedef enum logic [1:0] {PS_ACTIVE, PS_PD_PRE, PS_PD_ACT, PS_SELF_REF} ddrpp_pwr_type;
endpackage

// *** tb/ddrpp_host.sv ***
// Host controller model: link clock, command, address and parity pins.
// Assumes frame() is called by the bench and paced by the core clock.
module ddrpp_host (
  input  wire logic   core_clk_i, // Pacing clock
  output logic        ck_t_o,     // Link clock true
  output logic        ck_c_o,     // Link clock complement
  output logic        cs_n_o,     // Chip select, low
  output logic        act_n_o,    // Activate, low
  output logic [2:0]  rcw_n_o,    // Ras, cas, we
  output logic [1:0]  bg_o,       // Bank group
  output logic [1:0]  ba_o,       // Bank
  output logic [13:0] a_o,        // Address
  output logic        par_o       // Even parity
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ck_t_o, ck_c_o, cs_n_o, act_n_o, rcw_n_o, bg_o, ba_o, a_o, par_o} = {3'h3, 22'h0};
  end
  // Link clock stands still between frames
  task automatic frame(input logic c, ac, input logic [2:0] r, input logic [1:0] g, b,
                       input logic [13:0] ad, input bit bad);
    @(negedge core_clk_i);
    {cs_n_o, act_n_o, rcw_n_o, bg_o, ba_o, a_o} = {c, ac, r, g, b, ad};
    par_o = ^{ac, r, g, b, ad} ^ bad;
    repeat (10) @(negedge core_clk_i);
    {ck_t_o, ck_c_o} = 2'b10;
    repeat (10) @(negedge core_clk_i);
    {ck_t_o, ck_c_o} = 2'b01;
    cs_n_o = 1'b1;
    // Released lines show the inverse, not a stale value
    {act_n_o, rcw_n_o, bg_o, ba_o, a_o, par_o} = ~{act_n_o, rcw_n_o, bg_o, ba_o, a_o, par_o};
  endtask
endmodule

// *** tb/tb_ddr4_module_pin_protocol.sv ***
// Bench for the device block: command decode, banks, bursts, alert, power.
// Assumes ddrpp_host drives the command pins; the bench drives x8 lanes with DQ_W of 8.
`define CHK(n, e, s) check_val(n, 64'(e), 64'(s))
module tb_ddr4_module_pin_protocol import ddrpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic          core_clk_i, rst_n_i, cke, dqs_t, dm_n, odt, ck_t, ck_c, cs_n, act_n, par, c1, ac1, rd_tog;
  logic          dram_rst_n;
  logic [2:0]    rcw, r3;
  logic [1:0]    bg, ba, g2, b2, cmd_bg, cmd_ba;
  logic [13:0]   a, a14;
  logic [7:0]    dq, wr_data, dq_o;
  logic [63:0]   rd_data;
  logic [16:0]   cmd_addr;
  logic [15:0]   bank_open, banks;
  logic          cmd_valid, auto_pre, burst_chop, pre_all, odt_en, alert_n, wr_valid, dq_oe, dqs_to, dqs_co, dbi_n;
  ddrpp_cmd_type cmd_code;
  ddrpp_pwr_type pwr_state;
  logic [7:0]    wq[$], rq[$];
  int            error_cnt, compares, n_cmd, alert_lo, al0, cyc;
  bit            par_on, blk;
  integer        seed = 32'h7bc0;

  ddrpp_host ddrpp_host_inst (.core_clk_i(core_clk_i), .ck_t_o(ck_t), .ck_c_o(ck_c), .cs_n_o(cs_n),
    .act_n_o(act_n), .rcw_n_o(rcw), .bg_o(bg), .ba_o(ba), .a_o(a), .par_o(par));
  ddrpp_dev ddrpp_dev_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ck_t_i(ck_t), .ck_c_i(ck_c),
    .cke_i(cke), .cs_n_i(cs_n), .act_n_i(act_n), .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]),
    .bg_i(bg), .ba_i(ba), .a_i(a), .odt_i(odt), .par_i(par), .dram_rst_n_i(dram_rst_n), .dqs_t_i(dqs_t),
    .dqs_c_i(~dqs_t), .dq_i(dq), .dm_dbi_n_i(dm_n), .rd_data_i(rd_data), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_bg_o(cmd_bg), .cmd_ba_o(cmd_ba), .cmd_addr_o(cmd_addr),
    .auto_pre_o(auto_pre), .burst_chop_o(burst_chop), .pre_all_o(pre_all), .bank_open_o(bank_open),
    .pwr_state_o(pwr_state), .odt_en_o(odt_en), .alert_n_o(alert_n), .wr_valid_o(wr_valid),
    .wr_data_o(wr_data), .dq_o(dq_o), .dq_oe_o(dq_oe), .dqs_t_o(dqs_to), .dqs_c_o(dqs_co),
    .dqs_oe_o(), .dbi_n_o(dbi_n), .dbi_oe_o());

  task automatic check_val(input string n, input logic [63:0] e, input logic [63:0] s);
    compares++;
    if (e !== s) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cmd_valid === 1'b1) n_cmd++;
    if (alert_n === 1'b0) alert_lo++;
    if (wr_valid === 1'b1) `CHK("wr_data", wq.size() ? wq.pop_front() : 8'hxx, wr_data);
    if (dq_oe === 1'b1) begin
      `CHK("rd_beat", {1'b1, rq.size() ? rq.pop_front() : 8'hxx}, {dbi_n, dq_o});
      `CHK("rd_strobe", {rd_tog, ~rd_tog}, {dqs_to, dqs_co});
      rd_tog = ~rd_tog;
    end else rd_tog = 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // Model of acceptance, checked after every frame, and of open rows, checked after accepted ones
  task automatic cmd(input logic c, ac, input logic [2:0] r, input logic [1:0] g, b,
                     input logic [13:0] ad, input bit bad);
    int  n0;
    bit  acc;
    logic [3:0] k;
    n0 = n_cmd;
    k = {g, b};
    acc = !c && !(par_on && bad) && !blk;
    odt = 1'($random(seed));
    ddrpp_host_inst.frame(c, ac, r, g, b, ad, bad);
    repeat (6) @(negedge core_clk_i);
    `CHK("accepted", acc, n_cmd - n0);
    if (bad) `CHK("alert", 1'b0, alert_n);
    if (acc) begin
      if (!ac) banks[k] = 1'b1;
      else if (r == 3'h2) banks = ad[10] ? 16'h0 : banks & ~(16'h1 << k);
      else if (r[2:1] == 2'b10 && ad[10]) banks[k] = 1'b0;
      `CHK("code", ac ? {1'b0, r} + 4'h1 : CMD_ACT, cmd_code);
      `CHK("addr", {r, ad, g, b}, {cmd_addr, cmd_bg, cmd_ba});
      `CHK("open", banks, bank_open);
      if (!(ac && r == 3'h0)) `CHK("odt", odt, odt_en);
      if (ac && r[2:1] == 2'b10) `CHK("ap_bc", {ad[10], ~ad[12]}, {auto_pre, burst_chop});
      if (ac && r == 3'h2) `CHK("pre_all", ad[10], pre_all);
    end
  endtask

  initial begin
    {rst_n_i, cke, dqs_t, dm_n, odt, par_on, blk, rd_tog} = 8'h0;
    {dq, rd_data, banks} = 88'h0;
    dram_rst_n = 1'b1;
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    cke = 1'b1;
    repeat (3) @(negedge core_clk_i);
    cmd(0, 1, 3'h0, 2'h0, 2'h0, 14'h0001, 0);
    cmd(0, 1, 3'h0, 2'h0, 2'h1, 14'h0100, 0);
    cmd(0, 1, 3'h0, 2'h1, 2'h1, 14'h0801, 0);
    par_on = 1'b1;
    for (int i = 0; i < 60; i++) begin
      {c1, ac1, r3, g2, b2, a14} = 23'($random(seed));
      // Bursts have their own scenarios; spare mode register only
      if (ac1 && r3[2:1] == 2'b10) r3 = 3'h7;
      if (ac1 && r3 == 3'h0) {g2, b2} = 4'h4;
      cmd(c1, ac1, r3, g2, b2, a14, 0);
    end
    cmd(0, 0, 3'h0, 2'h0, 2'h0, 14'h0123, 0);
    // Second pass swaps write inversion for masking
    for (int j = 0; j < 2; j++) begin
      if (j) cmd(0, 1, 3'h0, 2'h1, 2'h1, 14'h0401, 0);
      cmd(0, 1, 3'h4, 2'h0, 2'h0, 14'h1010, 0);
      for (int i = 0; i < 8; i++) begin
        {dq, dm_n} = 9'($random(seed));
        if (!j || dm_n) wq.push_back((j || dm_n) ? dq : ~dq);
        dqs_t = ~dqs_t;
        repeat (4) @(negedge core_clk_i);
      end
      `CHK("wr_left", 0, wq.size());
    end
    for (int j = 0; j < 2; j++) begin
      rd_data = {$random(seed), $random(seed)};
      for (int i = 0; i < (j ? 4 : 8); i++) rq.push_back(rd_data[i*8 +: 8]);
      cmd(0, 1, 3'h5, 2'h0, 2'h0, j ? 14'h0410 : 14'h1010, 0);
      `CHK("rd_left", 0, rq.size());
    end
    al0 = alert_lo;
    cmd(0, 1, 3'h7, 2'h0, 2'h0, 14'h0000, 1);
    blk = 1'b1;
    cmd(0, 1, 3'h7, 2'h0, 2'h0, 14'h0000, 0);
    blk = 1'b0;
    repeat (40) @(negedge core_clk_i);
    `CHK("alert_len", PAR_REC_CYC, alert_lo - al0);
    for (int j = 0; j < 2; j++) begin
      cmd(0, j == 0, j ? 3'h0 : 3'h2, 2'h0, 2'h0, j ? 14'h0 : 14'h0400, 0);
      cke = 1'b0;
      // Entry needs a link clock rise; deselected so no command
      ddrpp_host_inst.frame(1, 1, 3'h7, 2'h0, 2'h0, 14'h0000, 0);
      repeat (6) @(negedge core_clk_i);
      `CHK("pwr", j ? PS_PD_ACT : PS_PD_PRE, pwr_state);
      blk = 1'b1;
      cmd(0, 1, 3'h7, 2'h0, 2'h0, 14'h0000, 0);
      {cke, blk} = 2'b10;
      ddrpp_host_inst.frame(0, 1, 3'h7, 2'h0, 2'h0, 14'h0000, 0);
      repeat (6) @(negedge core_clk_i);
      `CHK("pwr", PS_ACTIVE, pwr_state);
    end
    cmd(0, 1, 3'h2, 2'h0, 2'h0, 14'h0400, 0);
    cke = 1'b0;
    ddrpp_host_inst.frame(0, 1, 3'h1, 2'h0, 2'h0, 14'h0000, 0);
    repeat (6) @(negedge core_clk_i);
    `CHK("pwr", PS_SELF_REF, pwr_state);
    `CHK("sr_odt", 0, odt_en);
    // Exit needs no link clock edge
    cke = 1'b1;
    repeat (6) @(negedge core_clk_i);
    `CHK("pwr", PS_ACTIVE, pwr_state);
    cmd(0, 0, 3'h0, 2'h1, 2'h2, 14'h0042, 0);
    dram_rst_n = 1'b0;
    repeat (4) @(negedge core_clk_i);
    dram_rst_n = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `CHK("rst_open", 0, bank_open);
    `CHK("rst_alert", 1, alert_n);
    finish_test();
  end
endmodule
